// *** rtl/pmcsc_pkg.sv ***
package pmcsc_pkg;
  // register byte addresses in the special-function space
  localparam logic [7:0] PMCSC_EXTENDED_FLAG_REGISTER_ADDR = 8'h91;
  localparam logic [7:0] PMCSC_POWER_CONTROL_REGISTER_ADDR = 8'h87;
  localparam logic [7:0] PMCSC_PMR_ADDR = 8'hc4;
  localparam logic [7:0] PMCSC_STATUS_ADDR = 8'hc5;
  // field positions
  localparam int PMCSC_EXTENDED_FLAG_REGISTER_SRC_BIT = 3;
  localparam int PMCSC_EXTENDED_FLAG_REGISTER_RING_BIT = 2;
  localparam int PMCSC_PMR_DIV_HI = 7;
  localparam int PMCSC_PMR_DIV_LO = 6;
  localparam int PMCSC_PMR_SWB_BIT = 5;
  localparam int PMCSC_PMR_AMP_BIT = 3;
  localparam int PMCSC_POWER_CONTROL_REGISTER_IDLE_BIT = 0;
  localparam int PMCSC_ST_READY_BIT = 4;
  // divider codes and clocks per instruction cycle
  localparam logic [1:0] PMCSC_DIV_RSVD = 2'h0;
  localparam logic [1:0] PMCSC_DIV_4 = 2'h1;
  localparam logic [1:0] PMCSC_DIV_64 = 2'h2;
  localparam logic [1:0] PMCSC_DIV_1024 = 2'h3;
  localparam logic [10:0] PMCSC_CLKS_4 = 11'h004;
  localparam logic [10:0] PMCSC_CLKS_64 = 11'h040;
  localparam logic [10:0] PMCSC_CLKS_1024 = 11'h400;
  // reset values
  localparam logic [1:0] PMCSC_DIV_RST = PMCSC_DIV_4;
  localparam logic PMCSC_SRC_RST = 1'b1;
  localparam logic PMCSC_READY_RST = 1'b1;
  localparam logic PMCSC_SWB_RST = 1'b0;
  localparam logic PMCSC_AMP_OFF_RST = 1'b0;
  // crystal warm-up in crystal clocks after the oscillator starts
  localparam int PMCSC_WARMUP_CLKS = 65536;

  typedef struct packed {
    logic powerfail_level_active;
    logic high_level_active;
    logic low_level_active;
    logic port1_tx_busy;
    logic port1_rx_busy;
    logic port0_tx_busy;
    logic port0_rx_busy;
  } pmcsc_activity_s;

  typedef struct packed {
    logic ext_irq_serviceable;
    logic rx_start_edge;
    logic tx_buffer_write;
  } pmcsc_wake_s;
endpackage : pmcsc_pkg

// *** rtl/pmcsc_top.sv ***
// Function
// - status bit 7 mirrors power-fail service level
// - status bits 6,5 mirror high/low service
// - status bit 0 shows port 0 receiving
// - status bit 1 shows port 0 transmitting
// - status bits 3,2 show port 1 activity
// - extended flag bit 3 selects crystal or ring
// - reset runs from crystal, source independent
// - extended flag bit 2 reads ring active
// - amplifier-off bit settable only with ring selected
// - source change applies after one instruction cycle
// - clearing amplifier-off restarts warm-up, then ready
// - crystal select refused until crystal ready
// - switchback restores divider only, not source
// - divider bits 7:6 decode, reset 01
// - switchback enable bit 5 gates hardware switchback
// - ready resets to 1; status read-only
// - control bit 0 enters idle
// - any interrupt or reset leaves idle
// - reduced modes divide by 64 and 1024
// - reduced mode only entered from divide-by-4
// - switchback on interrupt, start edge, transmit write
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/10ps
module pmcsc_top
  import pmcsc_pkg::*;
#(
  parameter int WARMUP_CLKS = PMCSC_WARMUP_CLKS
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire pmcsc_activity_s ACTIVITY,
  input wire pmcsc_wake_s WAKE,
  input wire logic ANY_IRQ,
  input wire logic XTAL_RUNNING,
  output logic AMP_ENABLE,
  output logic CPU_SRC_XTAL,
  output logic RING_ACTIVE,
  output logic [1:0] DIV_ACTIVE,
  output logic CYCLE_STB,
  output logic IDLE
);

  ////////////////////////////////////////////////////////////////////////////
  // clocks per cycle
  function automatic logic [10:0] clks_per_cycle(input logic [1:0] code);
    case (code)
      PMCSC_DIV_64: clks_per_cycle = PMCSC_CLKS_64;
      PMCSC_DIV_1024: clks_per_cycle = PMCSC_CLKS_1024;
      default: clks_per_cycle = PMCSC_CLKS_4;
    endcase
  endfunction : clks_per_cycle

  logic [1:0] div_r;
  logic [1:0] div_act_r;
  logic src_sel_r;
  logic src_act_r;
  logic swb_r;
  logic amp_off_r;
  logic amp_en_r;
  logic ready_r;
  logic idle_r;
  logic stb_r;
  logic ring_r;
  logic [10:0] cyc_cnt_r;
  logic [16:0] warm_cnt_r;
  logic [7:0] status_r;
  logic [7:0] rdata_r;
  logic boundary;
  logic wr_pmr;
  logic wr_extended_flag_register;
  logic switchback;
  logic [1:0] div_wr;

  assign wr_pmr = WR && (ADDR == PMCSC_PMR_ADDR);
  assign wr_extended_flag_register = WR && (ADDR == PMCSC_EXTENDED_FLAG_REGISTER_ADDR);
  assign div_wr = WDATA[PMCSC_PMR_DIV_HI:PMCSC_PMR_DIV_LO];
  assign boundary = (cyc_cnt_r == clks_per_cycle(div_act_r) - 11'h001);
  assign switchback = swb_r && (WAKE.ext_irq_serviceable || WAKE.rx_start_edge
                                || WAKE.tx_buffer_write);

  ////////////////////////////////////////////////////////////////////////////
  // status mirror; the write path never touches it
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      status_r <= 8'h00;
    end else begin
      status_r[7] <= ACTIVITY.powerfail_level_active;
      status_r[6] <= ACTIVITY.high_level_active;
      status_r[5] <= ACTIVITY.low_level_active;
      status_r[3] <= ACTIVITY.port1_tx_busy;
      status_r[2] <= ACTIVITY.port1_rx_busy;
      status_r[1] <= ACTIVITY.port0_tx_busy;
      status_r[0] <= ACTIVITY.port0_rx_busy;
      status_r[4] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // divider select; hardware switchback outranks a same-cycle write
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      div_r <= PMCSC_DIV_RST;
      swb_r <= PMCSC_SWB_RST;
    end else begin
      if (wr_pmr) begin
        swb_r <= WDATA[PMCSC_PMR_SWB_BIT];
      end
      if (switchback) begin
        div_r <= PMCSC_DIV_4;
      // limitation: a reserved code is dropped silently and never reads back
      end else if (wr_pmr && div_wr != PMCSC_DIV_RSVD) begin
        if (div_wr == PMCSC_DIV_4 || div_r == PMCSC_DIV_4) begin
          div_r <= div_wr;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // source select and amplifier control
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      src_sel_r <= PMCSC_SRC_RST;
      amp_off_r <= PMCSC_AMP_OFF_RST;
      amp_en_r <= !PMCSC_AMP_OFF_RST;
    end else begin
      if (wr_extended_flag_register) begin
        if (!WDATA[PMCSC_EXTENDED_FLAG_REGISTER_SRC_BIT] || src_sel_r || (ready_r && !amp_off_r)) begin
          src_sel_r <= WDATA[PMCSC_EXTENDED_FLAG_REGISTER_SRC_BIT];
        end
      end
      if (wr_pmr) begin
        if (!WDATA[PMCSC_PMR_AMP_BIT] || !src_sel_r) begin
          amp_off_r <= WDATA[PMCSC_PMR_AMP_BIT];
          amp_en_r <= !WDATA[PMCSC_PMR_AMP_BIT];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // warm-up counts crystal clocks once the oscillator shows activity
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ready_r <= PMCSC_READY_RST;
      warm_cnt_r <= 17'h00000;
    // ready falls one edge after amplifier-off rises; polling software sees it late
    end else if (amp_off_r) begin
      ready_r <= 1'b0;
      warm_cnt_r <= 17'h00000;
    end else if (!ready_r && XTAL_RUNNING) begin
      if (warm_cnt_r == 17'(WARMUP_CLKS - 1)) begin
        ready_r <= 1'b1;
      end else begin
        warm_cnt_r <= warm_cnt_r + 17'h00001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // instruction-cycle divider; new settings land only on a boundary so the
  // cpu never sees a truncated cycle
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      cyc_cnt_r <= 11'h000;
      div_act_r <= PMCSC_DIV_RST;
      src_act_r <= PMCSC_SRC_RST;
      stb_r <= 1'b0;
      ring_r <= 1'b0;
    end else begin
      stb_r <= boundary;
      if (boundary) begin
        cyc_cnt_r <= 11'h000;
        div_act_r <= div_r;
        if (src_sel_r == 1'b0 || !amp_off_r) begin
          src_act_r <= src_sel_r;
          ring_r <= !src_sel_r;
        end
      end else begin
        cyc_cnt_r <= cyc_cnt_r + 11'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // idle: an interrupt in the same cycle as the entering write wins
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      idle_r <= 1'b0;
    end else if (ANY_IRQ) begin
      idle_r <= 1'b0;
    end else if (WR && ADDR == PMCSC_POWER_CONTROL_REGISTER_ADDR && WDATA[PMCSC_POWER_CONTROL_REGISTER_IDLE_BIT]) begin
      idle_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port, data valid the cycle after the strobe
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rdata_r <= 8'h00;
    end else if (RD) begin
      case (ADDR)
        PMCSC_PMR_ADDR: rdata_r <= {div_r, swb_r, 1'b0, amp_off_r, 3'h0};
        PMCSC_STATUS_ADDR: rdata_r <= status_r | {3'h0, ready_r, 4'h0};
        PMCSC_EXTENDED_FLAG_REGISTER_ADDR: rdata_r <= {4'h0, src_sel_r, ring_r, 2'h0};
        PMCSC_POWER_CONTROL_REGISTER_ADDR: rdata_r <= {7'h00, idle_r};
        default: rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign RDATA = rdata_r;
  assign AMP_ENABLE = amp_en_r;
  assign CPU_SRC_XTAL = src_act_r;
  assign RING_ACTIVE = ring_r;
  assign DIV_ACTIVE = div_act_r;
  assign CYCLE_STB = stb_r;
  assign IDLE = idle_r;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  sequence s_reduced_write;
    wr_pmr && div_wr[1] && div_r != PMCSC_DIV_4 && !switchback;
  endsequence

  sequence s_early_xtal;
    wr_extended_flag_register && WDATA[PMCSC_EXTENDED_FLAG_REGISTER_SRC_BIT] && !src_sel_r && !ready_r;
  endsequence

  status_mirror_a: assert property (
    status_r[7:5] == $past({ACTIVITY.powerfail_level_active,
      ACTIVITY.high_level_active, ACTIVITY.low_level_active}))
    else $error("service level status not mirrored");

  serial_flags_a: assert property (
    status_r[3:0] == $past({ACTIVITY.port1_tx_busy, ACTIVITY.port1_rx_busy,
      ACTIVITY.port0_tx_busy, ACTIVITY.port0_rx_busy}))
    else $error("serial activity status not mirrored");

  early_xtal_refused_a: assert property (s_early_xtal |=> !src_sel_r)
    else $error("crystal selected before ready");

  amp_off_guard_a: assert property (
    wr_pmr && WDATA[PMCSC_PMR_AMP_BIT] && src_sel_r && !amp_off_r |=> !amp_off_r)
    else $error("amplifier turned off with crystal selected");

  reduced_refused_a: assert property (s_reduced_write |=> $stable(div_r))
    else $error("direct change between reduced modes");

  switchback_four_a: assert property (switchback |=> div_r == PMCSC_DIV_4)
    else $error("switchback did not restore divide by four");

  switchback_src_a: assert property (switchback && !wr_extended_flag_register |=> $stable(src_sel_r))
    else $error("switchback changed the clock source");

  boundary_apply_a: assert property (
    !boundary |=> $stable(div_act_r) && $stable(src_act_r))
    else $error("clock change away from cycle boundary");

  ready_drop_a: assert property ($rose(amp_off_r) |=> !ready_r)
    else $error("ready still set with amplifier off");

  ring_status_a: assert property (ring_r == !src_act_r)
    else $error("ring status disagrees with active source");

  idle_exit_a: assert property (idle_r && ANY_IRQ |=> !idle_r)
    else $error("interrupt did not end idle");

  amp_pin_a: assert property (amp_en_r == !amp_off_r)
    else $error("amplifier enable disagrees with amplifier-off bit");

  sequence s_warm_done;
    !amp_off_r && !ready_r && XTAL_RUNNING && warm_cnt_r == 17'(WARMUP_CLKS - 1);
  endsequence

  sequence s_xtal_amp_off;
    wr_extended_flag_register && WDATA[PMCSC_EXTENDED_FLAG_REGISTER_SRC_BIT] && !src_sel_r && amp_off_r;
  endsequence

  ready_set_a: assert property (s_warm_done |=> ready_r)
    else $error("ready not set after warm-up");

  ready_low_off_a: assert property (amp_off_r |=> !ready_r)
    else $error("ready held with amplifier off");

  xtal_amp_off_a: assert property (s_xtal_amp_off |=> !src_sel_r)
    else $error("crystal selected with amplifier off");

  xtal_needs_amp_a: assert property (amp_off_r |=> !$rose(src_act_r))
    else $error("crystal applied while amplifier off");

  cycle_count_a: assert property (cyc_cnt_r < clks_per_cycle(div_act_r))
    else $error("instruction cycle longer than its divider");

  stb_pulse_a: assert property (stb_r |=> !stb_r)
    else $error("cycle strobe wider than one clock");

  divider_apply_a: assert property (boundary |=> div_act_r == $past(div_r))
    else $error("boundary did not apply divider");

  swb_off_hold_a: assert property (!swb_r && !wr_pmr |=> $stable(div_r))
    else $error("divider changed without write or switchback");

  idle_enter_a: assert property (
    WR && ADDR == PMCSC_POWER_CONTROL_REGISTER_ADDR && WDATA[PMCSC_POWER_CONTROL_REGISTER_IDLE_BIT] && !ANY_IRQ |=> idle_r)
    else $error("write did not enter idle");

endmodule : pmcsc_top

// *** tb/pmcsc_xtal_model.sv ***
`timescale 1ns/10ps
module pmcsc_xtal_model #(
  parameter int STARTUP = 5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic amp_enable,
  output logic running
);
  int cnt;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      running <= 1'b1;
    end else if (!amp_enable) begin
      cnt <= 0;
      running <= 1'b0;
    end else if (cnt < STARTUP) begin
      cnt <= cnt + 1;
    end else begin
      running <= 1'b1;
    end
  end
endmodule : pmcsc_xtal_model

// *** tb/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
  import pmcsc_pkg::*;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, irq = 0, run, amp, src, ring, stb, idle;
  logic [7:0] addr = 0, wdata = 0, rdata;
  logic [1:0] div;
  pmcsc_activity_s act = '0;
  pmcsc_wake_s wake = '0;
  int errors = 0, check_count = 0, cyc = 0, i;
  always #12.5 clk = ~clk;
  pmcsc_top #(.WARMUP_CLKS(8)) uut (.CLK_SYS(clk), .RST_N(rst_n), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .ACTIVITY(act), .WAKE(wake),
    .ANY_IRQ(irq), .XTAL_RUNNING(run), .AMP_ENABLE(amp), .CPU_SRC_XTAL(src),
    .RING_ACTIVE(ring), .DIV_ACTIVE(div), .CYCLE_STB(stb), .IDLE(idle));
  pmcsc_xtal_model xm (.clk(clk), .rst_n(rst_n), .amp_enable(amp), .running(run));
  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t pin got %h exp %h", $time, got, exp);
    end
  endtask : chk_pin
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t reg got %h exp %h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rreg
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rreg(a, d);
    chk_reg(d, exp);
  endtask : rchk
  task automatic period(input logic [7:0] exp);
    int n;
    n = 0;
    while (stb !== 1'b1 && n < 2000) begin
      wt(1);
      n++;
    end
    n = 0;
    do begin
      wt(1);
      n++;
    end while (stb !== 1'b1 && n < 2000);
    chk_pin(8'(n), exp);
  endtask : period
  task automatic pulse_wake(input pmcsc_wake_s w);
    @(posedge clk);
    wake <= w;
    @(posedge clk);
    wake <= '0;
  endtask : pulse_wake
  // slow-clock bursts stay well below this ceiling
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] d;
    wt(8);
    rst_n = 1'b1;
    rchk(PMCSC_PMR_ADDR, 8'h40);
    rchk(PMCSC_STATUS_ADDR, 8'h10);
    rchk(PMCSC_EXTENDED_FLAG_REGISTER_ADDR, 8'h08);
    rchk(8'h00, 8'h00);
    chk_pin({4'h0, div, src, ring}, 8'h06);
    period(8'h04);
    $display("test reset done");
    @(posedge clk);
    act <= pmcsc_activity_s'(7'h55);
    wreg(PMCSC_STATUS_ADDR, 8'h00);
    rchk(PMCSC_STATUS_ADDR, 8'hb5);
    @(posedge clk);
    act <= pmcsc_activity_s'(7'h2a);
    wt(2);
    rchk(PMCSC_STATUS_ADDR, 8'h5a);
    @(posedge clk);
    act <= '0;
    $display("test status done");
    wreg(PMCSC_PMR_ADDR, 8'h48);
    rchk(PMCSC_PMR_ADDR, 8'h40);
    wreg(PMCSC_EXTENDED_FLAG_REGISTER_ADDR, 8'h00);
    wt(8);
    rchk(PMCSC_EXTENDED_FLAG_REGISTER_ADDR, 8'h04);
    chk_pin({6'h0, src, ring}, 8'h01);
    wreg(PMCSC_PMR_ADDR, 8'h48);
    wt(2);
    chk_pin({7'h0, amp}, 8'h00);
    rchk(PMCSC_STATUS_ADDR, 8'h00);
    wreg(PMCSC_EXTENDED_FLAG_REGISTER_ADDR, 8'h08);
    rchk(PMCSC_EXTENDED_FLAG_REGISTER_ADDR, 8'h04);
    wreg(PMCSC_PMR_ADDR, 8'h40);
    i = 0;
    do begin
      rreg(PMCSC_STATUS_ADDR, d);
      i++;
    end while (d[PMCSC_ST_READY_BIT] !== 1'b1 && i < 40);
    chk_pin(8'(i > 5), 8'h01);
    chk_reg({3'h0, d[PMCSC_ST_READY_BIT], 4'h0}, 8'h10);
    chk_pin({7'h0, amp}, 8'h01);
    wreg(PMCSC_EXTENDED_FLAG_REGISTER_ADDR, 8'h08);
    wt(8);
    rchk(PMCSC_EXTENDED_FLAG_REGISTER_ADDR, 8'h08);
    chk_pin({6'h0, src, ring}, 8'h02);
    $display("test source done");
    rchk(PMCSC_STATUS_ADDR, 8'h10);
    wreg(PMCSC_PMR_ADDR, 8'h80);
    wt(8);
    chk_pin({6'h0, div}, 8'h02);
    period(8'h40);
    wreg(PMCSC_PMR_ADDR, 8'hc0);
    rchk(PMCSC_PMR_ADDR, 8'h80);
    pulse_wake(pmcsc_wake_s'(3'h4));
    wt(2);
    chk_pin({6'h0, div}, 8'h02);
    wreg(PMCSC_PMR_ADDR, 8'h40);
    wreg(PMCSC_EXTENDED_FLAG_REGISTER_ADDR, 8'h00);
    for (i = 0; i < 3; i++) begin
      wreg(PMCSC_PMR_ADDR, 8'ha0);
      wt(70);
      chk_pin({6'h0, div}, 8'h02);
      // pulses a transmit-buffer write, then a start edge, then a serviceable interrupt; each one is checked
      pulse_wake(pmcsc_wake_s'(3'h1 << i));
      wt(2);
      rchk(PMCSC_PMR_ADDR, 8'h60);
      period(8'h04);
      chk_pin({6'h0, div}, 8'h01);
      chk_pin({6'h0, src, ring}, 8'h01);
    end
    $display("test divider done");
    wreg(PMCSC_POWER_CONTROL_REGISTER_ADDR, 8'h01);
    wt(2);
    chk_pin({7'h0, idle}, 8'h01);
    @(posedge clk);
    irq <= 1'b1;
    @(posedge clk);
    irq <= 1'b0;
    wt(2);
    chk_pin({7'h0, idle}, 8'h00);
    $display("test idle done");
    conclude();
  end
endmodule : tb_top
